// [design/aoch_cfg.svh]
// Purpose: offsets, field positions, resets
// Assumes: byte addresses, one word each
// Notes: values in hundredths, signed
`ifndef AOCH_CFG_SVH
`define AOCH_CFG_SVH
`define AOCH_OFF_CMD   8'h00
`define AOCH_OFF_ARG   8'h04
`define AOCH_OFF_RESP  8'h08
`define AOCH_OFF_CKS   8'h0C
`define AOCH_OFF_CFG   8'h10
`define AOCH_OFF_RMIN  8'h14
`define AOCH_OFF_RMAX  8'h18
`define AOCH_OFF_UPLIM 8'h1C
`define AOCH_OFF_LOLIM 8'h20
`define AOCH_OFF_DAC   8'h24
`define AOCH_OFF_AOUT  8'h28
`define AOCH_OFF_LEN   8'h2C
`define AOCH_OFF_LBL   4'h3
`define AOCH_CKS_CLR_BIT 8
`define AOCH_RST_ADDR  8'h01
`define AOCH_RST_RMIN  32'h00000000
`define AOCH_RST_RMAX  32'h000007D0
`define AOCH_RST_UPLIM 32'h0098967F
`define AOCH_RST_LOLIM 32'hFF676981
`define AOCH_LF        8'h0A
`define AOCH_LABEL_MAX 5'h10
`endif

// [design/aoch_pkg.sv]
// Purpose: types of the output command handler
// Assumes: aoch_cfg.svh holds the numbers
// Notes: command word is cast from hwdata
package aoch_pkg;
  typedef enum logic [3:0] {
    AOCH_OP_NONE   = 4'b0000,
    AOCH_OP_ACK    = 4'b0001,
    AOCH_OP_SETOUT = 4'b0010,
    AOCH_OP_RDIN   = 4'b0011,
    AOCH_OP_RAWW   = 4'b0100,
    AOCH_OP_UPLIM  = 4'b0101,
    AOCH_OP_LOLIM  = 4'b0110,
    AOCH_OP_LABEL  = 4'b0111,
    AOCH_OP_WREN   = 4'b1000,
    AOCH_OP_OTHER  = 4'b1001
  } aoch_op_t;
  typedef enum logic [2:0] {
    AOCH_RS_NONE   = 3'b000,
    AOCH_RS_ACK    = 3'b001,
    AOCH_RS_ECHO   = 3'b010,
    AOCH_RS_LIMERR = 3'b011,
    AOCH_RS_MANERR = 3'b100,
    AOCH_RS_REFUSE = 3'b101,
    AOCH_RS_ABORT  = 3'b110
  } aoch_resp_t;
  typedef struct packed {
    logic [15:0] unused;
    logic [7:0]  addr;
    logic [2:0]  rsv;
    logic        checked;
    aoch_op_t    op;
  } aoch_cmd_t;
  typedef struct packed {
    logic [2:0] din;
    logic       manual;
    logic       slewing;
  } aoch_pins_t;
endpackage : aoch_pkg

// [design/aoch_cksum.sv]
// Purpose: running message checksum
// Assumes: one byte per enable pulse
// Notes: parity bit and linefeed skipped
`include "aoch_cfg.svh"
module aoch_cksum (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clr_i,
  input  wire logic       add_i,
  input  wire logic [7:0] byte_i,
  output logic      [15:0] ascii_o
);
  logic [7:0] sum_q;
  logic [7:0] sum_d;
  logic [6:0] chr;

  // seven data bits only, linefeed never counted
  always_comb begin
    chr   = byte_i[6:0];
    sum_d = sum_q;
    if (clr_i) begin
      sum_d = 8'h00;
    end else if (add_i && ({1'b0, chr} != `AOCH_LF)) begin
      sum_d = sum_q + {1'b0, chr};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sum_q <= 8'h00;
    end else begin
      sum_q <= sum_d;
    end
  end

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    hex_chr = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_chr

  // low two hex digits as printable characters
  assign ascii_o = {hex_chr(sum_q[7:4]), hex_chr(sum_q[3:0])};
endmodule : aoch_cksum

// [design/aoch_top.sv]
// Purpose: output command handler behind AHB-Lite
// Assumes: commands arrive decoded in one word
// Notes: scaling to converter code sits downstream
// Notes: zero wait states, every reply OKAY; commands act
//        at the end of their data phase, loads pulse one cycle later
// Notes: write enable covers only the next addressed command
//
// What this block does
// - immediate form: update output, then acknowledge
// - checked form: echo, hold pending, no change
// - acknowledge executes pending output update
// - other valid command drops pending update
// - outside input range gives limit error
// - user high/low limits reject violating requests
// - manual mode wins; manual mode error
// - status reply: status byte, input byte
// - status byte 00 steady, 01 slewing
// - input two, one, zero in bits 2..0
// - true pins reported during manual mode
// - raw write loads 12-bit converter code
// - raw write skips every check
// - high limit stored; above it limit error
// - maximum high limit removes restriction
// - high limit needs prior write enable
// - high limit ignores raw and manual outputs
// - rescaling range keeps stored high limit
// - label up to 16 characters stored
// - long label or checked form aborted
// - label stored only after write enable
// - checksum: low byte of character sum
// - below low limit gives limit error
//
// Chosen here: the register addresses and the AHB-Lite register port.
`include "aoch_cfg.svh"
module aoch_top
  import aoch_pkg::*;
#(
  parameter int unsigned DAC_W = 12
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             hsel_i,
  input  wire logic [31:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic             hready_i,
  input  wire logic [31:0]      hwdata_i,
  output logic      [31:0]      hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  input  wire logic [2:0]       din_i,
  input  wire logic             manual_i,
  input  wire logic             slewing_i,
  output logic      [DAC_W-1:0] dac_code_o,
  output logic                  dac_load_o,
  output logic      [31:0]      aout_value_o,
  output logic                  aout_load_o
);
  typedef struct packed {
    // bus address phase held into the data phase
    logic             aph_wr;
    logic [7:0]       aph_addr;
    // command registers and limits
    logic [31:0]      arg;
    logic [31:0]      rmin;
    logic [31:0]      rmax;
    logic [31:0]      uplim;
    logic [31:0]      lolim;
    logic [31:0]      aout;
    logic             aout_ld;
    logic [DAC_W-1:0] dac;
    logic             dac_ld;
    logic [7:0]       modaddr;
    logic             pend;
    logic [31:0]      pend_val;
    logic             wren;
    // reply to the host
    aoch_resp_t       code;
    logic             done;
    logic [15:0]      stat;
    logic [3:0][31:0] stage;
    logic [3:0][31:0] label;
    logic [4:0]       label_len;
  } aoch_state_t;

  aoch_state_t s_q;
  aoch_state_t s_d;
  aoch_cmd_t   cmd;
  aoch_pins_t  pins;
  aoch_resp_t  ok_rs;
  logic        cmd_wr;
  logic        cks_clr;
  logic        cks_add;
  logic [15:0] cks_ascii;
  logic        range_bad;
  logic        user_bad;
  logic [31:0] rd;
  logic        own_cmd;
  logic        lbl_hit;
  logic        lbl_bad;
  logic [31:0] resp_word;

  // command word decoded straight from the write data
  assign cmd  = aoch_cmd_t'(hwdata_i);
  assign pins = '{din: din_i, manual: manual_i, slewing: slewing_i};

  // data-phase write decode
  assign cmd_wr  = s_q.aph_wr && (s_q.aph_addr == `AOCH_OFF_CMD);
  assign cks_add = s_q.aph_wr && (s_q.aph_addr == `AOCH_OFF_CKS)
                   && !hwdata_i[`AOCH_CKS_CLR_BIT];
  assign cks_clr = s_q.aph_wr && (s_q.aph_addr == `AOCH_OFF_CKS)
                   && hwdata_i[`AOCH_CKS_CLR_BIT];

  // checked form echoes, plain form acknowledges
  assign ok_rs = cmd.checked ? AOCH_RS_ECHO : AOCH_RS_ACK;

  assign range_bad = ($signed(s_q.arg) < $signed(s_q.rmin))
                     || ($signed(s_q.arg) > $signed(s_q.rmax));
  // user limits; top value passes all
  assign user_bad  = ($signed(s_q.arg) > $signed(s_q.uplim))
                     || ($signed(s_q.arg) < $signed(s_q.lolim));

  // command word aimed at this module only
  assign own_cmd   = cmd_wr && (cmd.addr == s_q.modaddr);
  // label window: staging on write, stored text on read
  assign lbl_hit   = (s_q.aph_addr[7:4] == `AOCH_OFF_LBL);
  // checked form or overlong text; length compared
  // unsigned, so a negative length counts as overlong
  assign lbl_bad   = cmd.checked || (s_q.arg > {27'h0, `AOCH_LABEL_MAX});
  // reply word; status half kept from the last status read
  assign resp_word = {s_q.stat, s_q.done, s_q.pend, s_q.wren, 2'b00,
                      s_q.code, 5'h00, s_q.label_len[2:0]};

  // sum of the message bytes the host feeds in
  aoch_cksum u_cksum (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clr_i   (cks_clr),
    .add_i   (cks_add),
    .byte_i  (hwdata_i[7:0]),
    .ascii_o (cks_ascii)
  );

  // next-state of the whole block
  always_comb begin
    s_d         = s_q;
    s_d.aout_ld = 1'b0;
    s_d.dac_ld  = 1'b0;
    // address phase capture, zero wait state; hwdata belongs
    // to the address held here, so decode waits one cycle
    s_d.aph_wr  = hsel_i && hready_i && htrans_i[1] && hwrite_i;
    if (hsel_i && hready_i && htrans_i[1]) begin
      s_d.aph_addr = haddr_i[7:0];
    end
    // plain register writes
    // unmapped writes fall through and are dropped
    if (s_q.aph_wr) begin
      case (s_q.aph_addr)
        `AOCH_OFF_ARG:  s_d.arg     = hwdata_i;
        `AOCH_OFF_CFG:  s_d.modaddr = hwdata_i[7:0];
        `AOCH_OFF_RMIN: s_d.rmin    = hwdata_i;
        `AOCH_OFF_RMAX: s_d.rmax    = hwdata_i;
        default: begin
          // staging only; text moves to the label on the command
          if (lbl_hit) begin
            s_d.stage[s_q.aph_addr[3:2]] = hwdata_i;
          end
        end
      endcase
    end
    // a new command word clears the last answer
    if (cmd_wr) begin
      s_d.done = 1'b0;
      s_d.code = AOCH_RS_NONE;
    end
    // foreign address: silent, only the answer cleared; pending and
    // enable survive, as the command was never meant for us
    if (own_cmd) begin
      s_d.done = 1'b1;
      s_d.code = ok_rs;
      // enable holds for exactly the next command
      s_d.wren = 1'b0;
      // any other valid command drops pending
      if (cmd.op != AOCH_OP_ACK) begin
        s_d.pend = 1'b0;
      end
      case (cmd.op)
        AOCH_OP_ACK: begin
          // an acknowledge with nothing held just answers
          s_d.code = AOCH_RS_ACK;
          if (s_q.pend && pins.manual) begin
            // manual mode wins over a held update too
            // the held value is dropped, not kept for later
            s_d.code = AOCH_RS_MANERR;
            s_d.pend = 1'b0;
          end else if (s_q.pend) begin
            s_d.aout    = s_q.pend_val;
            s_d.aout_ld = 1'b1;
            s_d.pend    = 1'b0;
          end
        end
        AOCH_OP_SETOUT: begin
          // order: manual, then range and limits, then form
          if (pins.manual) begin
            s_d.code = AOCH_RS_MANERR;
          end else if (range_bad || user_bad) begin
            s_d.code = AOCH_RS_LIMERR;
          end else if (cmd.checked) begin
            s_d.pend     = 1'b1;
            s_d.pend_val = s_q.arg;
            s_d.code     = AOCH_RS_ECHO;
          end else begin
            s_d.aout    = s_q.arg;
            s_d.aout_ld = 1'b1;
            s_d.code    = AOCH_RS_ACK;
          end
        end
        AOCH_OP_RDIN: begin
          // slewing flag only in bit 8
          // pins in bits 2..0, rest zero
          s_d.stat[15:9] = 7'h00;
          s_d.stat[8]    = pins.slewing;
          s_d.stat[7:3]  = 5'h00;
          s_d.stat[2:0]  = pins.din;
        end
        AOCH_OP_RAWW: begin
          // no range, limit or trim check
          // stored limits not applied here
          // not blocked by manual mode either
          s_d.dac    = s_q.arg[DAC_W-1:0];
          s_d.dac_ld = 1'b1;
        end
        AOCH_OP_UPLIM: begin
          // top value stored like any other
          if (s_q.wren) begin
            s_d.uplim = s_q.arg;
          end else begin
            s_d.code = AOCH_RS_REFUSE;
          end
        end
        AOCH_OP_LOLIM: begin
          // same enable rule as the upper limit
          if (s_q.wren) begin
            s_d.lolim = s_q.arg;
          end else begin
            s_d.code = AOCH_RS_REFUSE;
          end
        end
        AOCH_OP_LABEL: begin
          // too long or checked form aborts
          if (lbl_bad) begin
            s_d.code = AOCH_RS_ABORT;
          end else if (s_q.wren) begin
            // text kept, no other effect
            // staged words copied whole, length kept apart
            s_d.label     = s_q.stage;
            s_d.label_len = s_q.arg[4:0];
            s_d.code      = AOCH_RS_ACK;
          end else begin
            s_d.code = AOCH_RS_REFUSE;
          end
        end
        AOCH_OP_WREN: begin
          // re-armed here after the clear above
          s_d.wren = 1'b1;
        end
        default: begin
          // none and other commands: plain answer
          // they still drop a pending update above
          s_d.code = ok_rs;
        end
      endcase
    end
  end

  // one register for all state; limits come up fully open
  // and the range at its default span
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q           <= '0;
      s_q.rmin      <= `AOCH_RST_RMIN;
      s_q.rmax      <= `AOCH_RST_RMAX;
      s_q.uplim     <= `AOCH_RST_UPLIM;
      s_q.lolim     <= `AOCH_RST_LOLIM;
      s_q.modaddr   <= `AOCH_RST_ADDR;
      s_q.code      <= AOCH_RS_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // read mux on the captured address; unmapped reads zero
  // reads have no side effect, so a repeated read is harmless
  always_comb begin
    rd = 32'h00000000;
    case (s_q.aph_addr)
      `AOCH_OFF_ARG:   rd = s_q.arg;
      `AOCH_OFF_RESP:  rd = resp_word;
      `AOCH_OFF_CKS:   rd = {16'h0000, cks_ascii};
      `AOCH_OFF_CFG:   rd = {24'h000000, s_q.modaddr};
      `AOCH_OFF_RMIN:  rd = s_q.rmin;
      `AOCH_OFF_RMAX:  rd = s_q.rmax;
      `AOCH_OFF_UPLIM: rd = s_q.uplim;
      `AOCH_OFF_LOLIM: rd = s_q.lolim;
      `AOCH_OFF_DAC:   rd = {{(32-DAC_W){1'b0}}, s_q.dac};
      `AOCH_OFF_AOUT:  rd = s_q.aout;
      `AOCH_OFF_LEN:   rd = {27'h0, s_q.label_len};
      default: begin
        if (lbl_hit) begin
          rd = s_q.label[s_q.aph_addr[3:2]];
        end
      end
    endcase
  end

  // never stalls, always OKAY: every command finishes in its
  // own data phase, so there is nothing to wait for
  assign hrdata_o     = rd;
  assign hreadyout_o  = 1'b1;
  assign hresp_o      = 1'b0;
  assign dac_code_o   = s_q.dac;
  assign dac_load_o   = s_q.dac_ld;
  assign aout_value_o = s_q.aout;
  assign aout_load_o  = s_q.aout_ld;
endmodule : aoch_top

// [testbench/aoch_top_chk.sv]
// Purpose: port checks of the command handler
// Assumes: ARG is written before CMD
// Notes: loads follow the command data phase by one edge
`include "aoch_cfg.svh"
module aoch_top_chk
  import aoch_pkg::*;
#(
  parameter int unsigned DAC_W = 12
) (
  input wire logic             clk_i,
  input wire logic             rst_n_i,
  input wire logic             hsel_i,
  input wire logic [31:0]      haddr_i,
  input wire logic [1:0]       htrans_i,
  input wire logic             hwrite_i,
  input wire logic             hready_i,
  input wire logic [31:0]      hwdata_i,
  input wire logic             manual_i,
  input wire logic [DAC_W-1:0] dac_code_o,
  input wire logic             dac_load_o,
  input wire logic [31:0]      aout_value_o,
  input wire logic             aout_load_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        cmd_q;
  logic        arg_q;
  logic [31:0] argv_q;
  logic        wr_a;
  assign wr_a = hsel_i & hready_i & htrans_i[1] & hwrite_i;
  // data phase flags; copy of ARG as the expected value
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q  <= 1'b0;
      arg_q  <= 1'b0;
      argv_q <= 32'h0;
    end else begin
      cmd_q <= wr_a && haddr_i[7:0] == `AOCH_OFF_CMD;
      arg_q <= wr_a && haddr_i[7:0] == `AOCH_OFF_ARG;
      if (arg_q) begin
        argv_q <= hwdata_i;
      end
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_AOUT_CAUSE: assert property (aout_load_o |-> $past(cmd_q) &&
    $past(hwdata_i[3:0]) inside {AOCH_OP_SETOUT, AOCH_OP_ACK}) else $error("output load without command");
  AST_AOUT_PULSE: assert property ($rose(aout_load_o) |=> !aout_load_o) else $error("output load too long");
  AST_AOUT_HOLD: assert property (!aout_load_o |-> $stable(aout_value_o)) else $error("output moved");
  AST_NO_MANUAL: assert property (aout_load_o |-> !$past(manual_i)) else $error("output load in manual");
  AST_AOUT_VAL: assert property (aout_load_o && $past(hwdata_i[4:0]) == 5'h02 |->
    aout_value_o == argv_q) else $error("output value differs");
  AST_DAC_CAUSE: assert property (dac_load_o |-> $past(cmd_q) &&
    $past(hwdata_i[3:0]) == AOCH_OP_RAWW) else $error("code load without raw write");
  AST_DAC_HOLD: assert property (!dac_load_o |-> $stable(dac_code_o)) else $error("code moved");
  AST_DAC_VAL: assert property (dac_load_o |-> dac_code_o == argv_q[DAC_W-1:0]) else $error("code differs");
  // main traffic seen
  cover property (aout_load_o && $past(hwdata_i[3:0]) == AOCH_OP_ACK);
  cover property (aout_load_o && $past(hwdata_i[3:0]) == AOCH_OP_SETOUT);
  cover property (dac_load_o);
endmodule : aoch_top_chk
bind aoch_top aoch_top_chk #(.DAC_W(DAC_W)) i_aoch_top_chk (.clk_i, .rst_n_i, .hsel_i, .haddr_i,
  .htrans_i, .hwrite_i, .hready_i, .hwdata_i, .manual_i, .dac_code_o, .dac_load_o, .aout_value_o, .aout_load_o);

// [testbench/aoch_host.sv]
// Purpose: host model on the register bus
// Assumes: single word transfers, OKAY only
// Notes: write data inverted outside its data phase
module aoch_host (
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [31:0]      hwdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0;
  end
  // one transfer; waits on ready, however slow
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    logic rdy;
    @(posedge clk_i);
    hsel_o   <= 1'b1;
    htrans_o <= 2'b10;
    haddr_o  <= {24'h0, a};
    hwrite_o <= w;
    hwdata_o <= ~hwdata_o;
    // settled values stand until the rising edge, no race with it
    do begin
      @(negedge clk_i);
      rdy = hready_i;
      @(posedge clk_i);
    end while (rdy !== 1'b1);
    htrans_o <= 2'b00;
    hwdata_o <= d;
    do begin
      @(negedge clk_i);
      rdy = hready_i;
      r   = hrdata_i;
      @(posedge clk_i);
    end while (rdy !== 1'b1);
  endtask : xfer
endmodule : aoch_host

// [testbench/tb_analog_output_command_handler.sv]
// Purpose: self-checking bench of the command handler
// Assumes: module address 0x01, default range
// Notes: random pins and requests, fixed seed
`include "aoch_cfg.svh"
module tb_analog_output_command_handler;
  import aoch_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk_i = 1'b0;
  logic               rst_n_i = 1'b0;
  aoch_pins_t         pins = '0;
  logic               hsel, hwrite, hready, dac_load, aout_load, hresp;
  logic [1:0]         htrans;
  logic [31:0]        haddr, hwdata, hrdata, aout, rs;
  logic [11:0]        dac_code;
  logic [31:0]        cur = 32'h0;
  logic signed [31:0] up_m = `AOCH_RST_UPLIM;
  logic signed [31:0] lo_m = `AOCH_RST_LOLIM;
  logic [7:0]         s = 8'h0;
  string              msg = "#1HX07FF";
  int                 mismatches = 0;
  int                 n_checks = 0;
  int                 cyc = 0;
  always #25 clk_i = ~clk_i;
  aoch_host i_aoch_host (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));
  aoch_top i_aoch_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .din_i(pins.din), .manual_i(pins.manual), .slewing_i(pins.slewing),
    .dac_code_o(dac_code), .dac_load_o(dac_load), .aout_value_o(aout), .aout_load_o(aout_load));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    i_aoch_host.xfer(1'b0, a, 32'h0, rs);
    check(rs, e);
  endtask : rd_chk
  // ARG first, then the command word, then the reply
  task automatic cmd(input aoch_op_t op, input logic c, input logic [7:0] ad, input logic [31:0] arg);
    i_aoch_host.xfer(1'b1, `AOCH_OFF_ARG, arg, rs);
    i_aoch_host.xfer(1'b1, `AOCH_OFF_CMD, {16'h0, ad, 3'h0, c, op}, rs);
    i_aoch_host.xfer(1'b0, `AOCH_OFF_RESP, 32'h0, rs);
  endtask : cmd
  // manual first, then range and limits, then the form
  task automatic sv(input logic signed [31:0] v, input logic c);
    logic [2:0] e;
    cmd(AOCH_OP_SETOUT, c, 8'h01, v);
    e = pins.manual ? 3'h4 : (v < 0 || v > $signed(`AOCH_RST_RMAX) || v > up_m || v < lo_m) ? 3'h3 : 3'h1;
    if (c && e == 3'h1) e = 3'h2;
    if (e == 3'h1) cur = v;
    check(32'(rs[10:8]), 32'(e));
    check(aout, cur);
  endtask : sv
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction : hexc
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(49));
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk(`AOCH_OFF_UPLIM, `AOCH_RST_UPLIM);
    rd_chk(`AOCH_OFF_LOLIM, `AOCH_RST_LOLIM);
    rd_chk(8'h40, 32'h0);
    sv(1000, 1'b0);
    check(32'(hresp), 32'h0);
    sv(1500, 1'b1);
    check(32'(rs[14]), 32'h1);
    if (rs[10:8] == 3'h2) cmd(AOCH_OP_ACK, 1'b0, 8'h01, 32'h0);
    cur = 1500;
    check(aout, cur);
    sv(500, 1'b1);
    cmd(AOCH_OP_RDIN, 1'b0, 8'h01, 32'h0);
    cmd(AOCH_OP_ACK, 1'b0, 8'h01, 32'h0);
    check(aout, cur);
    sv(600, 1'b1);
    cmd(AOCH_OP_OTHER, 1'b0, 8'h01, 32'h0);
    check(32'(rs[14]), 32'h0);
    sv(700, 1'b1);
    pins.manual <= 1'b1;
    cmd(AOCH_OP_ACK, 1'b0, 8'h01, 32'h0);
    check(32'(rs[10:8]), 32'h4);
    check(aout, cur);
    pins.manual <= 1'b0;
    cmd(AOCH_OP_UPLIM, 1'b0, 8'h01, 1200);
    check(32'(rs[10:8]), 32'h5);
    cmd(AOCH_OP_WREN, 1'b0, 8'h01, 32'h0);
    cmd(AOCH_OP_UPLIM, 1'b0, 8'h01, 1200);
    up_m = 1200;
    rd_chk(`AOCH_OFF_UPLIM, 32'd1200);
    i_aoch_host.xfer(1'b1, `AOCH_OFF_RMAX, 32'h00000898, rs);
    rd_chk(`AOCH_OFF_UPLIM, 32'd1200);
    i_aoch_host.xfer(1'b1, `AOCH_OFF_RMAX, `AOCH_RST_RMAX, rs);
    sv(1300, 1'b0);
    cmd(AOCH_OP_RAWW, 1'b0, 8'h01, 32'hFFF);
    check(32'(dac_code), 32'hFFF);
    cmd(AOCH_OP_WREN, 1'b0, 8'h01, 32'h0);
    cmd(AOCH_OP_LOLIM, 1'b0, 8'h01, 300);
    lo_m = 300;
    sv(200, 1'b0);
    cmd(AOCH_OP_WREN, 1'b0, 8'h01, 32'h0);
    cmd(AOCH_OP_UPLIM, 1'b0, 8'h01, `AOCH_RST_UPLIM);
    up_m = `AOCH_RST_UPLIM;
    sv(1900, 1'b0);
    sv(2500, 1'b0);
    cmd(AOCH_OP_SETOUT, 1'b0, 8'h02, 700);
    check(32'(rs[15]), 32'h0);
    check(aout, cur);
    i_aoch_host.xfer(1'b1, `AOCH_OFF_CFG, 32'h00000002, rs);
    rd_chk(`AOCH_OFF_CFG, 32'h00000002);
    cmd(AOCH_OP_SETOUT, 1'b0, 8'h01, 800);
    check(32'(rs[15]), 32'h0);
    check(aout, cur);
    i_aoch_host.xfer(1'b1, `AOCH_OFF_CFG, {24'h0, `AOCH_RST_ADDR}, rs);
    cmd(AOCH_OP_LABEL, 1'b0, 8'h01, 5);
    check(32'(rs[10:8]), 32'h5);
    cmd(AOCH_OP_WREN, 1'b0, 8'h01, 32'h0);
    cmd(AOCH_OP_LABEL, 1'b0, 8'h01, 17);
    check(32'(rs[10:8]), 32'h6);
    cmd(AOCH_OP_LABEL, 1'b1, 8'h01, 5);
    check(32'(rs[10:8]), 32'h6);
    i_aoch_host.xfer(1'b1, {`AOCH_OFF_LBL, 4'h0}, 32'h4C414231, rs);
    cmd(AOCH_OP_WREN, 1'b0, 8'h01, 32'h0);
    cmd(AOCH_OP_LABEL, 1'b0, 8'h01, 16);
    rd_chk(`AOCH_OFF_LEN, 32'd16);
    rd_chk({`AOCH_OFF_LBL, 4'h0}, 32'h4C414231);
    // parity bits set at random, linefeed must not count
    i_aoch_host.xfer(1'b1, `AOCH_OFF_CKS, 32'h100, rs);
    foreach (msg[i]) begin
      s += msg[i];
      i_aoch_host.xfer(1'b1, `AOCH_OFF_CKS, {24'h0, 1'($urandom), msg[i][6:0]}, rs);
    end
    i_aoch_host.xfer(1'b1, `AOCH_OFF_CKS, 32'h0A, rs);
    rd_chk(`AOCH_OFF_CKS, {16'h0, hexc(s[7:4]), hexc(s[3:0])});
    // random pins, manual mode and requests
    repeat (24) begin
      pins <= aoch_pins_t'(5'($urandom));
      cmd(AOCH_OP_RDIN, 1'b0, 8'h01, 32'h0);
      check(32'(rs[31:16]), {16'h0, 7'h0, pins.slewing, 5'h0, pins.din});
      sv($urandom_range(2600) - 300, 1'($urandom));
    end
    end_sim();
  end
endmodule : tb_analog_output_command_handler
